//--- cbu_pkg.sv
package cbu_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_OFFSET = 8'h04;
    localparam logic [7:0] OFF_FLAGS = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // Control register fields
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_W = 4;
    localparam int CTRL_START_BIT = 8;

    // Flag register fields
    localparam int FLAG_N_BIT = 2;
    localparam int FLAG_V_BIT = 3;
    localparam int FLAG_H_BIT = 5;
    localparam int FLAG_T_BIT = 6;

    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TAKEN_BIT = 1;
    localparam int STAT_BADOP_BIT = 2;

    // Reset values
    localparam logic [3:0] RST_OP = 4'h0;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // Cycles per instruction: fall through, taken
    localparam int CYC_NOT_TAKEN = 1;
    localparam int CYC_TAKEN = 2;

    // Branch operations selected by the control register
    typedef enum logic [3:0] {
        OP_MINUS = 4'h0,
        OP_PLUS = 4'h1,
        OP_SIGNED_GE = 4'h2,
        OP_SIGNED_LT = 4'h3,
        OP_HALF_SET = 4'h4,
        OP_HALF_CLEAR = 4'h5,
        OP_XFER_SET = 4'h6,
        OP_XFER_CLEAR = 4'h7,
        OP_OVF_SET = 4'h8
    } cbu_op_type;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EVAL = 3'b010,
        ST_JUMP = 3'b100
    } cbu_state_type;

endpackage

//--- cbu_cond_if.sv
`timescale 1ns/10ps
// Operation and flags in, branch decision out
interface cbu_cond_if;
    logic [3:0] op;      // Latched operation code
    logic flag_n;        // Negative flag
    logic flag_v;        // Overflow flag
    logic flag_h;        // Half-carry flag
    logic flag_t;        // Transfer flag
    logic taken;         // Condition holds
    logic known;         // Operation code is one of ours

    modport eval (input op, flag_n, flag_v, flag_h, flag_t,
                  output taken, known);
    modport user (output op, flag_n, flag_v, flag_h, flag_t,
                  input taken, known);
endinterface

//--- cbu_cond.sv
`timescale 1ns/10ps
// Pure combinational branch condition evaluator
module cbu_cond (
    cbu_cond_if.eval bus
);

    // Signed comparison term
    wire sign_xor;
    assign sign_xor = bus.flag_n ^ bus.flag_v; // (RULE3) (RULE4)

    // Decision per operation; unknown codes never branch
    always_comb
    begin
        bus.taken = 1'b0;
        bus.known = 1'b1;
        case (bus.op)
            cbu_pkg::OP_MINUS: bus.taken = bus.flag_n; // (RULE1)
            cbu_pkg::OP_PLUS: bus.taken = ~bus.flag_n; // (RULE2)
            cbu_pkg::OP_SIGNED_GE: bus.taken = ~sign_xor; // (RULE3)
            cbu_pkg::OP_SIGNED_LT: bus.taken = sign_xor; // (RULE4)
            cbu_pkg::OP_HALF_SET: bus.taken = bus.flag_h; // (RULE5)
            cbu_pkg::OP_HALF_CLEAR: bus.taken = ~bus.flag_h; // (RULE6)
            cbu_pkg::OP_XFER_SET: bus.taken = bus.flag_t; // (RULE7)
            cbu_pkg::OP_XFER_CLEAR: bus.taken = ~bus.flag_t; // (RULE8)
            cbu_pkg::OP_OVF_SET: bus.taken = bus.flag_v; // (RULE9)
            default: bus.known = 1'b0;
        endcase
    end

endmodule

//--- cbu_branch_unit.sv
`timescale 1ns/10ps
// Contract
// (RULE1) Minus branches when negative flag is one
// (RULE2) Plus branches when negative flag is zero
// (RULE3) Signed ge branches when N xor V zero
// (RULE4) Signed lt branches when N xor V one
// (RULE5) Half-carry set branches when flag one
// (RULE6) Half-carry clear branches when flag zero
// (RULE7) Transfer set branches when flag one
// (RULE8) Transfer clear branches when flag zero
// (RULE9) Overflow set branches when flag one
// (RULE10) Flags untouched; one cycle, two if taken
// (RULE11) Offset sign-extended; target PC plus k plus one
module cbu_branch_unit #(
    parameter int PC_W = 12,   // Program counter width
    parameter int K_W = 7      // Signed offset width
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [PC_W-1:0] pc_o,
    output logic busy_o,
    output logic done_o,
    output logic taken_o
);

    // Expands byte selects into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // Merges write data into an old word under the byte mask
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = lane_mask(sel);
        return (old & ~m) | (dat & m);
    endfunction

    // Sequencer state
    cbu_pkg::cbu_state_type state_reg;
    cbu_pkg::cbu_state_type state_next;

    // Architectural and control storage
    logic [PC_W-1:0] pc_reg;        // Program counter
    logic [PC_W-1:0] pc_next;       // Its next value
    logic [K_W-1:0] k_reg;          // Branch offset
    logic [3:0] op_reg;             // Operation to run
    logic [31:0] flags_reg;         // Status flags seen by branches
    logic taken_reg;                // Outcome of last instruction
    logic bad_op_reg;               // Last operation was unknown
    logic done_reg;                 // Completion pulse
    logic busy_reg;                 // Instruction in flight
    logic ack_reg;                  // Bus acknowledge
    logic [31:0] dat_reg;           // Bus read data

    // Bus decode
    wire bus_req;
    wire bus_wr;
    wire bus_rd;
    wire hit_ctrl;
    wire hit_offset;
    wire hit_flags;
    wire hit_pc;
    wire hit_status;
    wire idle;
    wire [31:0] ctrl_word;
    wire [31:0] ctrl_merged;
    wire start;
    wire [31:0] rd_data;
    wire [31:0] pc_merged;          // Counter word after byte merge
    wire [31:0] k_merged;           // Offset word after byte merge
    assign pc_merged = merge({{(32-PC_W){1'b0}}, pc_reg}, wb_dat_i, wb_sel_i);
    assign k_merged = merge({{(32-K_W){1'b0}}, k_reg}, wb_dat_i, wb_sel_i);

    // New request, one per bus cycle until acknowledged
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign bus_wr = bus_req & wb_we_i;
    assign bus_rd = bus_req & ~wb_we_i;
    assign hit_ctrl = (wb_adr_i == cbu_pkg::OFF_CTRL);
    assign hit_offset = (wb_adr_i == cbu_pkg::OFF_OFFSET);
    assign hit_flags = (wb_adr_i == cbu_pkg::OFF_FLAGS);
    assign hit_pc = (wb_adr_i == cbu_pkg::OFF_PC);
    assign hit_status = (wb_adr_i == cbu_pkg::OFF_STATUS);
    assign idle = (state_reg == cbu_pkg::ST_IDLE);

    // Control word as read back; start bit never reads as set
    assign ctrl_word = {{(32-cbu_pkg::CTRL_OP_W){1'b0}}, op_reg};
    assign ctrl_merged = merge(ctrl_word, wb_dat_i, wb_sel_i);

    // Start only from idle; a start while busy is dropped
    assign start = bus_wr & hit_ctrl & idle
                   & ctrl_merged[cbu_pkg::CTRL_START_BIT];

    // Read data selection; unmapped offsets read zero
    assign rd_data =
        hit_ctrl ? ctrl_word :
        hit_offset ? {{(32-K_W){1'b0}}, k_reg} :
        hit_flags ? flags_reg :
        hit_pc ? {{(32-PC_W){1'b0}}, pc_reg} :
        hit_status ? {29'h0000_0000, bad_op_reg, taken_reg, busy_reg} :
        cbu_pkg::RST_ZERO;

    // Condition evaluation through the carrier interface
    cbu_cond_if cond_bus ();
    assign cond_bus.op = op_reg;
    assign cond_bus.flag_n = flags_reg[cbu_pkg::FLAG_N_BIT];
    assign cond_bus.flag_v = flags_reg[cbu_pkg::FLAG_V_BIT];
    assign cond_bus.flag_h = flags_reg[cbu_pkg::FLAG_H_BIT];
    assign cond_bus.flag_t = flags_reg[cbu_pkg::FLAG_T_BIT];

    cbu_cond u_cond (
        .bus(cond_bus.eval)
    );

    // Offset sign-extended to the counter width
    wire [PC_W-1:0] k_ext;
    wire [PC_W-1:0] pc_seq;
    wire [PC_W-1:0] pc_target;
    assign k_ext = {{(PC_W-K_W){k_reg[K_W-1]}}, k_reg}; // (RULE11)
    assign pc_seq = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
    assign pc_target = pc_reg + k_ext
                       + {{(PC_W-1){1'b0}}, 1'b1}; // (RULE11)

    // Next state and program counter
    always_comb
    begin
        state_next = state_reg;
        pc_next = pc_reg;
        case (state_reg)
            cbu_pkg::ST_IDLE:
            begin
                // Software may load the counter only between instructions
                if (bus_wr && hit_pc)
                begin
                    pc_next = pc_merged[PC_W-1:0];
                end
                if (start)
                begin
                    state_next = cbu_pkg::ST_EVAL;
                end
            end
            cbu_pkg::ST_EVAL:
            begin
                // Taken costs a second cycle, fall through ends here
                if (cond_bus.taken)
                begin
                    state_next = cbu_pkg::ST_JUMP; // (RULE10)
                end
                else
                begin
                    pc_next = pc_seq; // (RULE10)
                    state_next = cbu_pkg::ST_IDLE;
                end
            end
            cbu_pkg::ST_JUMP:
            begin
                // Relative load on the second cycle
                pc_next = pc_target; // (RULE11)
                state_next = cbu_pkg::ST_IDLE;
            end
            default:
            begin
                state_next = cbu_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer and counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= cbu_pkg::ST_IDLE;
            pc_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            pc_reg <= pc_next;
        end
    end

    // Operation, offset and flag registers, locked while busy
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            op_reg <= cbu_pkg::RST_OP;
            k_reg <= '0;
            flags_reg <= cbu_pkg::RST_ZERO;
        end
        else if (bus_wr && idle)
        begin
            if (hit_ctrl)
            begin
                op_reg <= ctrl_merged[cbu_pkg::CTRL_OP_LSB +: 4];
            end
            if (hit_offset)
            begin
                k_reg <= k_merged[K_W-1:0];
            end
            // Only software changes flags; branches never do
            if (hit_flags)
            begin
                flags_reg <= merge(flags_reg, wb_dat_i, wb_sel_i); // (RULE10)
            end
        end
    end

    // Outcome and status tracking
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            taken_reg <= 1'b0;
            bad_op_reg <= 1'b0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= (state_next != cbu_pkg::ST_IDLE);
            done_reg <= (state_reg != cbu_pkg::ST_IDLE)
                        && (state_next == cbu_pkg::ST_IDLE);
            if (state_reg == cbu_pkg::ST_EVAL)
            begin
                taken_reg <= cond_bus.taken;
                bad_op_reg <= ~cond_bus.known;
            end
        end
    end

    // Wishbone answer one cycle after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= cbu_pkg::RST_ZERO;
        end
        else
        begin
            ack_reg <= bus_req;
            if (bus_rd)
            begin
                dat_reg <= rd_data;
            end
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign pc_o = pc_reg;
    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign taken_o = taken_reg;

    // Cycle counter of the instruction in flight, for checking
    logic [1:0] run_cnt;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || idle)
        begin
            run_cnt <= 2'h0;
        end
        else
        begin
            run_cnt <= run_cnt + 2'h1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wire in_eval;
    assign in_eval = (state_reg == cbu_pkg::ST_EVAL);

    property p_minus;
        in_eval && op_reg == cbu_pkg::OP_MINUS
            |=> (state_reg == cbu_pkg::ST_JUMP) == $past(cond_bus.flag_n);
    endproperty
    a_minus: assert property (p_minus) // (RULE1)
        else $error("minus branch decision wrong");

    property p_plus;
        in_eval && op_reg == cbu_pkg::OP_PLUS && cond_bus.flag_n
            |=> idle && pc_reg == $past(pc_seq);
    endproperty
    a_plus: assert property (p_plus) // (RULE2)
        else $error("plus branch did not fall through");

    property p_ge;
        in_eval && op_reg == cbu_pkg::OP_SIGNED_GE
            |-> cond_bus.taken == ~(cond_bus.flag_n ^ cond_bus.flag_v);
    endproperty
    a_ge: assert property (p_ge) // (RULE3)
        else $error("signed ge decision wrong");

    property p_lt;
        in_eval && op_reg == cbu_pkg::OP_SIGNED_LT
            && (cond_bus.flag_n ^ cond_bus.flag_v) ##1 1'b1
            ##1 1'b1 |-> idle && pc_reg == $past(pc_target);
    endproperty
    a_lt: assert property (p_lt) // (RULE4)
        else $error("signed lt did not branch");

    property p_hs;
        in_eval && op_reg == cbu_pkg::OP_HALF_SET
            |=> (state_reg == cbu_pkg::ST_JUMP) == $past(cond_bus.flag_h);
    endproperty
    a_hs: assert property (p_hs) // (RULE5)
        else $error("half-carry set decision wrong");

    property p_hc;
        in_eval && op_reg == cbu_pkg::OP_HALF_CLEAR
            |=> (state_reg == cbu_pkg::ST_JUMP) == !$past(cond_bus.flag_h);
    endproperty
    a_hc: assert property (p_hc) // (RULE6)
        else $error("half-carry clear decision wrong");

    property p_ts;
        in_eval && op_reg == cbu_pkg::OP_XFER_SET
            |-> cond_bus.taken == cond_bus.flag_t;
    endproperty
    a_ts: assert property (p_ts) // (RULE7)
        else $error("transfer set decision wrong");

    property p_tc;
        in_eval && op_reg == cbu_pkg::OP_XFER_CLEAR
            |-> cond_bus.taken == !cond_bus.flag_t;
    endproperty
    a_tc: assert property (p_tc) // (RULE8)
        else $error("transfer clear decision wrong");

    property p_vs;
        in_eval && op_reg == cbu_pkg::OP_OVF_SET
            |=> (state_reg == cbu_pkg::ST_JUMP) == $past(cond_bus.flag_v);
    endproperty
    a_vs: assert property (p_vs) // (RULE9)
        else $error("overflow set decision wrong");

    property p_flags_stable;
        !idle |=> $stable(flags_reg);
    endproperty
    a_flags_stable: assert property (p_flags_stable) // (RULE10)
        else $error("flags changed during a branch");

    property p_cycles;
        done_reg |-> run_cnt == (taken_reg ?
            2'(cbu_pkg::CYC_TAKEN) : 2'(cbu_pkg::CYC_NOT_TAKEN));
    endproperty
    a_cycles: assert property (p_cycles) // (RULE10)
        else $error("instruction took wrong cycle count");

    property p_start_len;
        start |=> in_eval ##1 (idle || state_reg == cbu_pkg::ST_JUMP)
            ##[0:1] idle;
    endproperty
    a_start_len: assert property (p_start_len) // (RULE10)
        else $error("instruction longer than two cycles");

    property p_target;
        state_reg == cbu_pkg::ST_JUMP
            |=> pc_reg == PC_W'($past(pc_reg) + $past(k_ext) + 1'b1);
    endproperty
    a_target: assert property (p_target) // (RULE11)
        else $error("branch target wrong");

endmodule

//--- cbu_branch_unit_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench: Wishbone register access drives every branch
module cbu_branch_unit_tb_top;
    localparam int PC_W = 12; // Program counter width under test
    localparam int K_W = 7; // Offset width under test
    logic clk_i; // Core clock
    logic rst_i; // Synchronous reset
    logic wb_cyc_i; // Bus cycle
    logic wb_stb_i; // Bus strobe
    logic wb_we_i; // Write enable
    logic [7:0] wb_adr_i; // Byte address
    logic [3:0] wb_sel_i; // Byte enables
    logic [31:0] wb_dat_i; // Write data
    logic [31:0] wb_dat_o; // Read data
    logic wb_ack_o; // Acknowledge
    logic [PC_W-1:0] pc_o; // Program counter
    logic busy_o; // Instruction in flight
    logic done_o; // End of instruction pulse
    logic taken_o; // Last instruction branched
    int error_cnt; // Mismatches seen
    int tests_run; // Comparisons made
    int busy_cnt = 0; // Edges with busy high
    int done_cnt = 0; // Done pulses seen
    logic [31:0] rd; // Scratch read data

    // Device under test
    cbu_branch_unit #(.PC_W(PC_W), .K_W(K_W)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pc_o(pc_o), .busy_o(busy_o),
        .done_o(done_o), .taken_o(taken_o)
    );

    // Free-running 20 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Count busy cycles and done pulses per instruction
    always @(posedge clk_i)
    begin
        if (busy_o === 1'b1)
            busy_cnt <= busy_cnt + 1;
        if (done_o === 1'b1)
            done_cnt <= done_cnt + 1;
    end

    // Print counts and verdict, then stop
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time,
                     what, seen, exp);
        end
    endtask

    // A wait that ran out of its bound
    task automatic hang(input string what);
        error_cnt++;
        $display("MISMATCH at %0t: no answer on %s", $time, what);
        report_and_stop();
    endtask

    // One classic Wishbone cycle, held until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] dat, input logic [3:0] sel,
                            output logic [31:0] q);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1)
                break;
        end
        q = wb_dat_o;
        if (i == 16)
            hang("bus");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // Full-word write
    task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb_cycle(1'b1, adr, dat, 4'hf, q);
    endtask

    // Read and compare
    task automatic wb_check(input logic [7:0] adr, input logic [31:0] exp,
                            input string what);
        logic [31:0] q;
        wb_cycle(1'b0, adr, 32'h0000_0000, 4'hf, q);
        check(q, exp, what);
    endtask

    // Branch condition worked out independently; f is {t, h, v, n}
    function automatic logic cond(input logic [3:0] op, input logic [3:0] f);
        case (op)
            4'h0: return f[0];
            4'h1: return !f[0];
            4'h2: return !(f[0] ^ f[1]);
            4'h3: return f[0] ^ f[1];
            4'h4: return f[2];
            4'h5: return !f[2];
            4'h6: return f[3];
            4'h7: return !f[3];
            4'h8: return f[1];
            default: return 1'b0;
        endcase
    endfunction

    // Load state, execute one branch, check target, timing and flags
    task automatic run_op(input logic [3:0] op, input logic [3:0] f,
                          input logic [K_W-1:0] k, input logic [PC_W-1:0] pc0);
        logic [31:0] fl;
        logic [31:0] st;
        logic [PC_W-1:0] pc_exp;
        logic tk;
        int i;
        int b0;
        int d0;
        fl = 32'ha5a5_a500;
        fl[cbu_pkg::FLAG_N_BIT] = f[0];
        fl[cbu_pkg::FLAG_V_BIT] = f[1];
        fl[cbu_pkg::FLAG_H_BIT] = f[2];
        fl[cbu_pkg::FLAG_T_BIT] = f[3];
        tk = cond(op, f);
        pc_exp = pc0 + 12'h001;
        if (tk)
            pc_exp = pc_exp + {{(PC_W-K_W){k[K_W-1]}}, k};
        st = 32'h0000_0000;
        st[cbu_pkg::STAT_TAKEN_BIT] = tk;
        st[cbu_pkg::STAT_BADOP_BIT] = (op > 4'h8);
        wb_write(cbu_pkg::OFF_PC, 32'(pc0));
        wb_write(cbu_pkg::OFF_OFFSET, 32'(k));
        wb_write(cbu_pkg::OFF_FLAGS, fl);
        b0 = busy_cnt;
        d0 = done_cnt;
        wb_write(cbu_pkg::OFF_CTRL, (32'h1 << cbu_pkg::CTRL_START_BIT) | op);
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            #1;
            if (done_cnt != d0)
                break;
        end
        if (i == 8)
            hang("done");
        check(busy_cnt - b0, tk ? 2 : 1, "cycles");
        check(32'(taken_o), 32'(tk), "taken");
        check(32'(pc_o), 32'(pc_exp), "pc");
        wb_check(cbu_pkg::OFF_FLAGS, fl, "flags kept");
        wb_check(cbu_pkg::OFF_STATUS, st, "status");
        wb_check(cbu_pkg::OFF_PC, 32'(pc_exp), "pc reg");
        check(done_cnt - d0, 1, "done pulses");
    endtask

    // Main sequence
    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and an unmapped place
        check(32'(pc_o), 32'h0000_0000, "pc after reset");
        wb_check(cbu_pkg::OFF_FLAGS, 32'h0000_0000, "flags reset");
        wb_check(cbu_pkg::OFF_STATUS, 32'h0000_0000, "status reset");
        wb_write(8'h14, 32'hffff_ffff);
        wb_check(8'h14, 32'h0000_0000, "unmapped");
        // Byte-lane merge on the flag word
        wb_write(cbu_pkg::OFF_FLAGS, 32'h1122_3344);
        wb_cycle(1'b1, cbu_pkg::OFF_FLAGS, 32'hffff_ff00, 4'h2, rd);
        wb_check(cbu_pkg::OFF_FLAGS, 32'h1122_ff44, "sel merge");
        // Every branch kind against every flag pattern
        for (int o = 0; o < 9; o++)
        begin
            for (int fv = 0; fv < 16; fv++)
            begin
                run_op(4'(o), 4'(fv), 7'(fv * 8 + o) ^ 7'h55,
                       {4'(fv), 4'(o), 4'he});
            end
        end
        // Undefined operation falls through and flags itself
        run_op(4'hf, 4'hf, 7'h40, 12'h123);
        // Second reset in mid-run clears the counter
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check(32'(pc_o), 32'h0000_0000, "pc after second reset");
        check(32'(taken_o), 32'h0000_0000, "taken after second reset");
        report_and_stop();
    end
endmodule
